// file: design/pdc_regs.svh
// Purpose: register offsets, field positions, reset values and cycle counts
// Assumes: 32-bit APB, one register per aligned word
// Notes: definitions only
`ifndef PDC_REGS_SVH
`define PDC_REGS_SVH

`define PDC_ADDR_CNTPTR 8'h00
`define PDC_ADDR_ADRPTR 8'h04
`define PDC_ADDR_CTRL 8'h08
`define PDC_ADDR_SWAP 8'h0C
`define PDC_ADDR_STATUS 8'h10

`define PDC_PTR_SEL_BIT 0
`define PDC_CTRL_PEND_BIT 5
`define PDC_CTRL_DMAMASK_BIT 4
`define PDC_CTRL_EOBMASK_BIT 3
`define PDC_CTRL_PRL_HI 2
`define PDC_CTRL_PRL_LO 0
`define PDC_SWAP_EN_BIT 0
`define PDC_SWAP_TBL_BIT 1
`define PDC_SWAP_EOB_BIT 2
`define PDC_STATUS_BUSY_BIT 0
`define PDC_STATUS_ERR_BIT 1

`define PDC_RST_PTR 8'h00
`define PDC_RST_PRL 3'h0
`define PDC_TBL_STRIDE 8'h02

`define PDC_PRIO_LEVELS 8
`define PDC_SAMPLE_CYC 5
`define PDC_RF_XFER_CYC 8
`define PDC_MEM_XFER_CYC 16
`define PDC_RF_MAX_BYTES 8'hDE
`define PDC_MEM_MAX_BYTES 65536

`endif

// file: design/pdc_pkg.sv
// Purpose: types shared by the dma channel and its arbiter
// Assumes: nothing
// Notes: constants live in pdc_regs.svh
package pdc_pkg;

	typedef enum logic [1:0] {PDC_IDLE, PDC_RUN, PDC_PAD} pdc_fsm_t;

	typedef struct packed {
		logic req;
		logic we;
		logic rf;
		logic [23:0] addr;
		logic [7:0] wdata;
	} pdc_acc_t;

	typedef struct packed {
		pdc_fsm_t fsm;
		logic [7:0] cntPtr;
		logic [7:0] adrPtr;
		logic pend;
		logic dmaMask;
		logic eobMask;
		logic [2:0] source_priority;
		logic swapEn;
		logic tbl;
		logic eobPend;
		logic descErr;
		logic abort;
		logic [15:0] cnt;
		logic [15:0] addr;
		logic [3:0] step;
		logic [4:0] timer;
		logic rfMode;
		logic segSel;
		logic toTarget;
		logic [7:0] pdata;
		pdc_acc_t acc;
		logic [7:0] periphOut;
		logic periphStb;
		logic dmaAck;
		logic [31:0] prdata;
		logic pslverr;
	} pdc_chan_t;

	typedef struct packed {
		logic [2:0] cnt;
		logic dmaGrant;
		logic intGrant;
	} pdc_arb_t;

endpackage

// file: design/pdc_arbiter.sv
// Purpose: samples dma and interrupt requests and picks a winner
// Assumes: all inputs from logic on clk_sys
// Notes: level 0 is the highest priority
`timescale 1ns/1ps
`default_nettype none
`include "pdc_regs.svh"

module pdc_arbiter import pdc_pkg::*; #(
	parameter int SAMPLE_CYC = `PDC_SAMPLE_CYC
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic dmaReq,
	input wire logic [2:0] sourcePriority,
	input wire logic dmaTaken,
	input wire logic busy,
	input wire logic intReq,
	input wire logic [2:0] intLevel,
	input wire logic [2:0] currentPriorityLevel,
	input wire logic topIsrActive,
	output logic dmaGrant,
	output logic intGrant
);

	localparam logic [2:0] TICK_LAST = 3'(SAMPLE_CYC - 1);

	pdc_arb_t st_reg;
	pdc_arb_t st_next;
	logic dmaOk;
	logic intOk;

	always_comb begin
		st_next = st_reg;
		st_next.intGrant = 1'b0;
		dmaOk = dmaReq && !topIsrActive && (sourcePriority <= currentPriorityLevel);
		intOk = intReq && (intLevel < currentPriorityLevel);
		if (st_reg.cnt == TICK_LAST) begin
			st_next.cnt = 3'h0;
		end else begin
			st_next.cnt = st_reg.cnt + 3'h1;
		end
		if (dmaTaken || !dmaReq) begin
			st_next.dmaGrant = 1'b0;
		end
		// no grants while a transfer runs
		if (st_reg.cnt == TICK_LAST && !busy && !st_reg.dmaGrant) begin
			if (dmaOk && (!intOk || sourcePriority <= intLevel)) begin
				st_next.dmaGrant = 1'b1;
			end else if (intOk) begin
				st_next.intGrant = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign dmaGrant = st_reg.dmaGrant;
	assign intGrant = st_reg.intGrant;

endmodule
`default_nettype wire

// file: design/pdc_channel.sv
// Purpose: peripheral dma channel with descriptors held in the register file
// Assumes: APB register access, same-clock peripheral and cpu signals
// Notes: descriptor and data accesses go through one byte-wide access port
//
// Notes on behaviour
// - one block moves at most 222 register-file bytes or 65536 memory bytes.
// - dma shares the eight interrupt levels; grant runs at instruction end.
// - dma beats an interrupt at the same priority level.
// - dma needs priority equal or higher than current; interrupt strictly higher.
// - dma never changes current priority and is not interruptible.
// - each transfer moves one byte, increments address, decrements counter.
// - register-file mode: address at even register, counter at next odd one.
// - counter pointer bit 0 set selects register file, clear selects memory.
// - memory mode: address and counter are 16-bit register pairs.
// - address pointer bit 0 picks dma or interrupt segment extension.
// - dma request is pending bit and dma request mask together.
// - counter reaching zero clears mask and raises end-of-block interrupt.
// - no dma acknowledge while the top-level interrupt service runs.
// - requests are sampled once every five cpu clock cycles.
// - a register-file transfer takes eight cpu clock cycles.
// - a memory transfer takes sixteen cycles plus wait states.
// - swap mode flips descriptor table, keeps mask, still raises interrupt.
// - swap keeps alternating tables 0 and 1 while enabled.
// - control register: pending 5, dma mask 4, eob mask 3, priority 2:0.
// - priority code 000 is level 0 highest, 111 is level 7 lowest.
// - pending set by event, cleared on acknowledge, writable by software.
// - pointer registers bits 7:1 locate the descriptors.
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pdc_regs.svh"

module pdc_channel import pdc_pkg::*; #(
	parameter int RF_XFER_CYC = `PDC_RF_XFER_CYC,
	parameter int MEM_XFER_CYC = `PDC_MEM_XFER_CYC,
	parameter int SAMPLE_CYC = `PDC_SAMPLE_CYC
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic periphEvent,
	input wire logic periphToTarget,
	input wire logic [7:0] periphRdata,
	output logic [7:0] periphWdata,
	output logic periphWrStb,
	output logic memReq,
	output logic memWe,
	output logic memRegfile,
	output logic [23:0] memAddr,
	output logic [7:0] memWdata,
	input wire logic [7:0] memRdata,
	input wire logic memReady,
	input wire logic [7:0] interruptSegmentExtension,
	input wire logic [7:0] dmaSegmentExtension,
	input wire logic [2:0] currentPriorityLevel,
	input wire logic topIsrActive,
	input wire logic instrEnd,
	input wire logic intReq,
	input wire logic [2:0] intLevel,
	output logic intGrant,
	output logic dmaAck,
	output logic eobIrq,
	output logic [2:0] eobIrqLevel,
	input wire logic eobAck
);

	localparam logic [4:0] RF_LAST = 5'(RF_XFER_CYC - 1);
	localparam logic [4:0] MEM_LAST = 5'(MEM_XFER_CYC - 1);

	pdc_chan_t st_reg;
	pdc_chan_t st_next;
	logic dmaReq;
	logic dmaGrant;
	logic take;
	logic busy;
	logic done;
	logic apbSetup;
	logic apbWrite;
	logic eobSet;
	logic errSet;

	// descriptor base of the active table
	function automatic logic [7:0] pdcBase(input logic [7:0] ptr, input logic tbl);
		pdcBase = {ptr[7:1], 1'b0} + (tbl ? `PDC_TBL_STRIDE : 8'h00);
	endfunction

	// access issued at a given step of the transfer
	function automatic pdc_acc_t pdcAccess(input pdc_chan_t s, input logic [7:0] segInt,
		input logic [7:0] segDma);
		logic [7:0] cb;
		logic [7:0] ab;
		pdc_acc_t a;
		cb = pdcBase(s.cntPtr, s.tbl);
		ab = pdcBase(s.adrPtr, s.tbl);
		a = '0;
		a.req = 1'b1;
		a.rf = 1'b1;
		case ({s.rfMode, s.step})
			5'h10: a.addr = {16'h0000, cb};
			5'h11: a.addr = {16'h0000, cb + 8'h01};
			5'h13: begin
				a.addr = {16'h0000, cb};
				a.we = 1'b1;
				a.wdata = s.addr[7:0];
			end
			5'h14: begin
				a.addr = {16'h0000, cb + 8'h01};
				a.we = 1'b1;
				a.wdata = s.cnt[7:0];
			end
			5'h00: a.addr = {16'h0000, cb};
			5'h01: a.addr = {16'h0000, cb + 8'h01};
			5'h02: a.addr = {16'h0000, ab};
			5'h03: a.addr = {16'h0000, ab + 8'h01};
			5'h05: begin
				a.addr = {16'h0000, ab};
				a.we = 1'b1;
				a.wdata = s.addr[15:8];
			end
			5'h06: begin
				a.addr = {16'h0000, ab + 8'h01};
				a.we = 1'b1;
				a.wdata = s.addr[7:0];
			end
			5'h07: begin
				a.addr = {16'h0000, cb};
				a.we = 1'b1;
				a.wdata = s.cnt[15:8];
			end
			5'h08: begin
				a.addr = {16'h0000, cb + 8'h01};
				a.we = 1'b1;
				a.wdata = s.cnt[7:0];
			end
			5'h12, 5'h04: begin
				// the data byte itself
				a.rf = s.rfMode;
				a.we = s.toTarget;
				a.wdata = s.pdata;
				if (s.rfMode) begin
					a.addr = {16'h0000, s.addr[7:0]};
				end else begin
					a.addr = {s.segSel ? segDma : segInt, s.addr};
				end
			end
			default: a = '0;
		endcase
		pdcAccess = a;
	endfunction

	pdc_arbiter #(
		.SAMPLE_CYC(SAMPLE_CYC)
	) u_arb (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.dmaReq(dmaReq),
		.sourcePriority(st_reg.source_priority),
		.dmaTaken(take),
		.busy(busy),
		.intReq(intReq),
		.intLevel(intLevel),
		.currentPriorityLevel(currentPriorityLevel),
		.topIsrActive(topIsrActive),
		.dmaGrant(dmaGrant),
		.intGrant(intGrant)
	);

	assign dmaReq = st_reg.pend && st_reg.dmaMask;
	assign busy = (st_reg.fsm != PDC_IDLE);
	assign take = (st_reg.fsm == PDC_IDLE) && dmaGrant && dmaReq && instrEnd;
	assign done = st_reg.acc.req && memReady;
	assign apbSetup = psel && !penable;
	assign apbWrite = psel && penable && pwrite;

	always_comb begin
		st_next = st_reg;
		st_next.dmaAck = 1'b0;
		st_next.periphStb = 1'b0;
		eobSet = 1'b0;
		errSet = 1'b0;
		// read data is captured in the setup cycle
		if (apbSetup) begin
			st_next.pslverr = 1'b0;
			case (paddr)
				`PDC_ADDR_CNTPTR: st_next.prdata = {24'h000000, st_reg.cntPtr};
				`PDC_ADDR_ADRPTR: st_next.prdata = {24'h000000, st_reg.adrPtr};
				`PDC_ADDR_CTRL: st_next.prdata = {26'h0000000, st_reg.pend, st_reg.dmaMask,
					st_reg.eobMask, st_reg.source_priority};
				`PDC_ADDR_SWAP: st_next.prdata = {29'h00000000, st_reg.eobPend, st_reg.tbl,
					st_reg.swapEn};
				`PDC_ADDR_STATUS: st_next.prdata = {st_reg.cnt, 14'h0000, st_reg.descErr, busy};
				default: begin
					st_next.prdata = 32'h00000000;
					st_next.pslverr = 1'b1;
				end
			endcase
		end
		case (st_reg.fsm)
			PDC_IDLE: begin
				if (take) begin
					st_next.pend = 1'b0;
					st_next.dmaAck = 1'b1;
					st_next.fsm = PDC_RUN;
					st_next.step = 4'h0;
					st_next.timer = 5'h00;
					st_next.abort = 1'b0;
					st_next.rfMode = st_reg.cntPtr[`PDC_PTR_SEL_BIT];
					st_next.segSel = st_reg.adrPtr[`PDC_PTR_SEL_BIT];
					st_next.toTarget = periphToTarget;
					st_next.pdata = periphRdata;
					st_next.acc = pdcAccess(st_next, interruptSegmentExtension,
						dmaSegmentExtension);
				end
			end
			PDC_RUN: begin
				// wait states are not counted
				if (!(st_reg.acc.req && !memReady)) begin
					st_next.timer = st_reg.timer + 5'h01;
				end
				if (done) begin
					case ({st_reg.rfMode, st_reg.step})
						5'h10: st_next.addr = {8'h00, memRdata};
						5'h11: begin
							st_next.cnt = {8'h00, memRdata};
							if (memRdata == 8'h00 || memRdata > `PDC_RF_MAX_BYTES) begin
								st_next.abort = 1'b1;
								errSet = 1'b1;
							end
						end
						5'h00: st_next.cnt[15:8] = memRdata;
						5'h01: st_next.cnt[7:0] = memRdata;
						5'h02: st_next.addr[15:8] = memRdata;
						5'h03: st_next.addr[7:0] = memRdata;
						5'h12, 5'h04: begin
							if (!st_reg.toTarget) begin
								st_next.periphOut = memRdata;
								st_next.periphStb = 1'b1;
							end
							st_next.addr = st_reg.rfMode ? {8'h00, st_reg.addr[7:0] + 8'h01}
								: st_reg.addr + 16'h0001;
							st_next.cnt = st_reg.rfMode ? {8'h00, st_reg.cnt[7:0] - 8'h01}
								: st_reg.cnt - 16'h0001;
						end
						default: st_next.step = st_reg.step;
					endcase
					st_next.step = st_reg.step + 4'h1;
					st_next.acc = pdcAccess(st_next, interruptSegmentExtension,
						dmaSegmentExtension);
					if (st_next.abort) begin
						st_next.acc = '0;
					end
					if (!st_next.acc.req) begin
						st_next.fsm = PDC_PAD;
					end
				end
			end
			PDC_PAD: begin
				st_next.timer = st_reg.timer + 5'h01;
				// descriptors are written back before leaving unless a bad descriptor aborted the block
				if (st_reg.timer >= (st_reg.rfMode ? RF_LAST : MEM_LAST)) begin
					st_next.fsm = PDC_IDLE;
					if (st_reg.abort) begin
						st_next.dmaMask = 1'b0;
					end else if (st_reg.cnt == 16'h0000) begin
						eobSet = 1'b1;
						if (st_reg.swapEn) begin
							st_next.tbl = !st_reg.tbl;
						end else begin
							st_next.dmaMask = 1'b0;
						end
					end
				end
			end
			default: st_next.fsm = PDC_IDLE;
		endcase
		if (eobAck) begin
			st_next.eobPend = 1'b0;
		end
		if (apbWrite) begin
			case (paddr)
				`PDC_ADDR_CNTPTR: st_next.cntPtr = pwdata[7:0];
				`PDC_ADDR_ADRPTR: st_next.adrPtr = pwdata[7:0];
				`PDC_ADDR_CTRL: begin
					st_next.pend = pwdata[`PDC_CTRL_PEND_BIT];
					st_next.dmaMask = pwdata[`PDC_CTRL_DMAMASK_BIT];
					st_next.eobMask = pwdata[`PDC_CTRL_EOBMASK_BIT];
					st_next.source_priority = pwdata[`PDC_CTRL_PRL_HI:`PDC_CTRL_PRL_LO];
				end
				`PDC_ADDR_SWAP: begin
					st_next.swapEn = pwdata[`PDC_SWAP_EN_BIT];
					if (pwdata[`PDC_SWAP_EOB_BIT]) begin
						st_next.eobPend = 1'b0;
					end
				end
				`PDC_ADDR_STATUS: begin
					if (pwdata[`PDC_STATUS_ERR_BIT]) begin
						st_next.descErr = 1'b0;
					end
				end
				default: st_next.cntPtr = st_next.cntPtr;
			endcase
		end
		// hardware sets win over clears in the same cycle
		if (periphEvent) begin
			st_next.pend = 1'b1;
		end
		if (eobSet) begin
			st_next.eobPend = 1'b1;
		end
		if (errSet) begin
			st_next.descErr = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
			st_reg.fsm <= PDC_IDLE;
			st_reg.cntPtr <= `PDC_RST_PTR;
			st_reg.adrPtr <= `PDC_RST_PTR;
			st_reg.source_priority <= `PDC_RST_PRL;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.prdata;
	assign pready = 1'b1;
	assign pslverr = st_reg.pslverr && psel && penable;
	assign periphWdata = st_reg.periphOut;
	assign periphWrStb = st_reg.periphStb;
	assign memReq = st_reg.acc.req;
	assign memWe = st_reg.acc.we;
	assign memRegfile = st_reg.acc.rf;
	assign memAddr = st_reg.acc.addr;
	assign memWdata = st_reg.acc.wdata;
	assign dmaAck = st_reg.dmaAck;
	assign eobIrq = st_reg.eobPend && st_reg.eobMask;
	assign eobIrqLevel = st_reg.source_priority;

endmodule
`default_nettype wire

// file: sim/pdc_channel_sva.sv
// Purpose: port checks on the dma channel
// Assumes: one clock domain
// Notes: bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module pdc_sva (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pslverr,
	input wire logic instrEnd,
	input wire logic intReq,
	input wire logic [2:0] intLevel,
	input wire logic [2:0] currentPriorityLevel,
	input wire logic memReq,
	input wire logic memReady,
	input wire logic memWe,
	input wire logic memRegfile,
	input wire logic [23:0] memAddr,
	input wire logic periphWrStb,
	input wire logic dmaAck,
	input wire logic intGrant,
	input wire logic eobIrq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("slave error outside access phase");
	property p_stall; memReq && !memReady |=> memReq && $stable(memAddr) && $stable(memWe); endproperty
	a_stall: assert property (p_stall) else $error("access changed in wait state");
	property p_take; dmaAck |-> $past(instrEnd); endproperty
	a_take: assert property (p_take) else $error("ack without instruction end");
	property p_desc; dmaAck |-> memReq && memRegfile && !memWe; endproperty
	a_desc: assert property (p_desc) else $error("first access not descriptor read");
	property p_gap; dmaAck |=> !dmaAck [*7]; endproperty
	a_gap: assert property (p_gap) else $error("transfer shorter than eight cycles");
	property p_samp; intGrant |=> !intGrant [*4]; endproperty
	a_samp: assert property (p_samp) else $error("grants closer than sample period");
	property p_lvl; intGrant |-> $past(intReq && intLevel < currentPriorityLevel); endproperty
	a_lvl: assert property (p_lvl) else $error("interrupt granted at low level");
	property p_stb; periphWrStb |=> !periphWrStb; endproperty
	a_stb: assert property (p_stb) else $error("peripheral strobe too long");
	c_ack: cover property (dmaAck);
	c_int: cover property (intGrant);
	c_eob: cover property (eobIrq);
endmodule
`default_nettype wire

// file: sim/pdc_far_model.sv
// Purpose: register file and memory behind the access port
// Assumes: low address byte indexes each space
// Notes: waitCyc stretches every access
`timescale 1ns/1ps
`default_nettype none
module pdc_far_model (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic memReq,
	input wire logic memWe,
	input wire logic memRegfile,
	input wire logic [23:0] memAddr,
	input wire logic [7:0] memWdata,
	input wire logic [3:0] waitCyc,
	output logic [7:0] memRdata,
	output logic memReady
);
	logic [7:0] rf [256];
	logic [7:0] mem [256];
	logic [7:0] segSeen;
	logic [3:0] w;
	assign memReady = memReq && w >= waitCyc;
	assign memRdata = !memReady ? ~memAddr[7:0] : memRegfile ? rf[memAddr[7:0]] : mem[memAddr[7:0]];
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			w <= 4'h0;
		end else if (memReady) begin
			w <= 4'h0;
			if (!memRegfile)
				segSeen <= memAddr[23:16];
			if (memWe && memRegfile)
				rf[memAddr[7:0]] <= memWdata;
			if (memWe && !memRegfile)
				mem[memAddr[7:0]] <= memWdata;
		end else if (memReq) begin
			w <= w + 4'h1;
		end
	end
endmodule
`default_nettype wire

// file: sim/peripheral_dma_channel_tb_top.sv
// Purpose: bench for the dma channel
// Assumes: far model answers the access port
// Notes: inputs change at rising edges
`timescale 1ns/1ps
`default_nettype none
module peripheral_dma_channel_tb_top;
	logic clk_sys, resetn = 0, psel = 0, penable = 0, pwrite = 0, periphEvent = 0;
	logic periphToTarget = 1, instrEnd = 1, intReq = 0, topIsrActive = 0, eobAck = 0;
	logic [7:0] paddr = 8'h00, periphRdata = 8'h00, gotW;
	logic [7:0] interruptSegmentExtension = 8'h3C, dmaSegmentExtension = 8'hC3;
	logic [2:0] currentPriorityLevel = 3'h3, intLevel = 3'h0, eobIrqLevel;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic [3:0] waitCyc = 4'h0;
	logic pready, pslverr, periphWrStb, memReq, memWe, memRegfile, memReady, ev;
	logic intGrant, dmaAck, eobIrq;
	logic [7:0] periphWdata, memWdata, memRdata;
	logic [23:0] memAddr;
	int miscompares = 0, checkCount = 0, acks = 0, ints = 0, firstWin = 0, cyc = 0;
	pdc_channel pdc_channel_inst (.*);
	pdc_far_model pdc_far_model_inst (.*);
	initial begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		instrEnd <= ((cyc % 3) == 2);
		if (dmaAck === 1'h1) acks <= acks + 1;
		if (intGrant === 1'h1) ints <= ints + 1;
		if (periphWrStb === 1'h1) gotW <= periphWdata;
		if (firstWin == 0 && (dmaAck === 1'h1 || intGrant === 1'h1)) firstWin <= dmaAck ? 1 : 2;
		if (cyc == 6000) begin
			miscompares++;
			printVerdict;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		checkCount++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		do @(posedge clk_sys); while (pready !== 1'h1);
		rv = prdata;
		ev = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk_sys);
	endtask
	task automatic xfer(input int n, input logic trig);
		int k;
		periphEvent <= trig;
		@(posedge clk_sys);
		periphEvent <= 0;
		for (k = 0; k < 80 && acks < n; k++) @(posedge clk_sys);
		do begin
			apb(0, 8'h10, 32'h0);
		end while (rv[0] !== 1'h0);
		chk(acks, n);
	endtask
	task printVerdict;
		$display("checks %0d mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		resetn <= 1;
		@(posedge clk_sys);
		apb(0, 8'h14, 32'h0);
		chk(ev, 1'h1);
		pdc_far_model_inst.rf[8'h20] = 8'h40;
		pdc_far_model_inst.rf[8'h21] = 8'h02;
		apb(1, 8'h00, 32'h21);
		apb(1, 8'h08, 32'h1B);
		periphRdata <= 8'hA5;
		xfer(1, 1);
		chk(pdc_far_model_inst.rf[8'h40], 8'hA5);
		chk(pdc_far_model_inst.rf[8'h20], 8'h41);
		chk(pdc_far_model_inst.rf[8'h21], 8'h01);
		periphRdata <= 8'h3C;
		xfer(2, 1);
		chk(pdc_far_model_inst.rf[8'h41], 8'h3C);
		chk({eobIrq, eobIrqLevel}, 4'hB);
		apb(0, 8'h08, 32'h0);
		chk(rv[5:4], 2'h0);
		eobAck <= 1;
		@(posedge clk_sys);
		eobAck <= 0;
		pdc_far_model_inst.rf[8'h21] = 8'h05;
		apb(1, 8'h08, 32'h34);
		repeat (30) @(posedge clk_sys);
		chk(acks, 2);
		currentPriorityLevel <= 3'h4;
		topIsrActive <= 1;
		intReq <= 1;
		intLevel <= 3'h4;
		repeat (30) @(posedge clk_sys);
		chk(acks + ints, 2);
		currentPriorityLevel <= 3'h5;
		topIsrActive <= 0;
		xfer(3, 0);
		chk(firstWin, 1);
		repeat (20) @(posedge clk_sys);
		chk(ints > 0, 1'h1);
		intReq <= 0;
		waitCyc <= 4'h3;
		periphToTarget <= 0;
		pdc_far_model_inst.rf[8'h31] = 8'h01;
		pdc_far_model_inst.rf[8'h33] = 8'h01;
		pdc_far_model_inst.rf[8'h50] = 8'h12;
		pdc_far_model_inst.rf[8'h51] = 8'h34;
		pdc_far_model_inst.rf[8'h53] = 8'h80;
		pdc_far_model_inst.rf[8'h30] = 8'h00;
		pdc_far_model_inst.rf[8'h32] = 8'h00;
		pdc_far_model_inst.rf[8'h52] = 8'h00;
		pdc_far_model_inst.mem[8'h34] = 8'h77;
		pdc_far_model_inst.mem[8'h80] = 8'h99;
		apb(1, 8'h00, 32'h30);
		apb(1, 8'h04, 32'h51);
		apb(1, 8'h0C, 32'h1);
		apb(1, 8'h08, 32'h1C);
		xfer(4, 1);
		chk(gotW, 8'h77);
		chk(pdc_far_model_inst.segSeen, 8'hC3);
		chk(pdc_far_model_inst.rf[8'h51], 8'h35);
		apb(0, 8'h0C, 32'h0);
		chk(rv[2:0], 3'h7);
		apb(0, 8'h08, 32'h0);
		chk(rv[4], 1'h1);
		apb(1, 8'h04, 32'h50);
		xfer(5, 1);
		chk(gotW, 8'h99);
		chk(pdc_far_model_inst.segSeen, 8'h3C);
		apb(0, 8'h0C, 32'h0);
		chk(rv[1], 1'h0);
		waitCyc <= 4'h0;
		pdc_far_model_inst.rf[8'h21] = 8'hDF;
		apb(1, 8'h0C, 32'h0);
		apb(1, 8'h00, 32'h21);
		xfer(6, 1);
		chk(rv[1], 1'h1);
		apb(0, 8'h08, 32'h0);
		chk(rv[4], 1'h0);
		chk(eobIrq, 1'h1);
		apb(1, 8'h08, 32'h04);
		chk(eobIrq, 1'h0);
		printVerdict;
	end
endmodule
bind pdc_channel pdc_sva pdc_sva_inst (.*);
`default_nettype wire
